/* File: adcc_pkg.sv */
// adcc_pkg: shared constants for the converter control ends
package adcc_pkg;
	localparam int CLK_PERIOD_NS = 100;
	// master clock ticks; TRIM_CONVS counts conversions
	localparam int CAL_TICKS = 1443840;
	localparam int SLICE_TICKS = 20;
	localparam int TRIM_CONVS = 72192;
	localparam int CONV_TICKS = 17;
	localparam int ACQ_TICKS = 3;
	// clk_i cycles; HOLD_LOW_NS and RST_PULSE_NS are in ns
	localparam int INT_DIV = 4;
	localparam int EXT_TIMEOUT = 16;
	localparam int SER_HALF = 2;
	localparam int MCLK_HALF = 2;
	localparam int HOLD_LOW_NS = 400;
	localparam int HOLD_LOW_CYC = (HOLD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_PULSE_NS = 400;
	localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RD_HOLD_CYC = 6;
	// adc status byte fields
	localparam int ST_CAL = 0;
	localparam int ST_CONV = 1;
	localparam int ST_EOC = 2;
	localparam int ST_TRIM = 3;
	localparam int ST_EXT = 4;
	// host wishbone map (byte addresses)
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_CMD = 8'h04;
	localparam logic [7:0] A_STAT = 8'h08;
	localparam logic [7:0] A_RESULT = 8'h0C;
	localparam logic [7:0] A_ADCST = 8'h10;
	localparam logic [7:0] A_IRQST = 8'h14;
	localparam logic [7:0] A_IRQMSK = 8'h18;
	// ctrl bits
	localparam int C_BURST = 0;
	localparam int C_TRIM = 1;
	localparam int C_EXTCLK = 2;
	localparam int C_AUTORD = 3;
	// cmd bits
	localparam int K_START = 0;
	localparam int K_RESET = 1;
	localparam int K_STATRD = 2;
	// irq bits
	localparam int I_RESULT = 0;
	localparam int I_STATUS = 1;
	localparam int I_ACQ = 2;
	localparam logic [31:0] CTRL_RST = 32'h0000_0008;
	typedef enum logic [2:0] {
		S_CAL = 3'b000,
		S_IDLE = 3'b001,
		S_CONV = 3'b010,
		S_SLICE = 3'b011,
		S_ACQ = 3'b100
	} adcc_state_e;
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_READ = 2'b01,
		H_GAP = 2'b10
	} adcc_hstate_e;
endpackage

/* File: adcc_if.sv */
// adcc_if: pins between converter and controller
`timescale 1ns/100ps
interface adcc_if;
	logic hold_n;
	logic acquired_n;
	logic cs_n;
	logic rd_n;
	logic result_status_select;
	logic cal_burst;
	logic interleave_trim_n;
	logic adc_reset;
	logic master_clock_in;
	logic [15:0] data_out;
	logic data_oe_n;
	logic eoc_n;
	logic serial_clk;
	logic serial_result_out;
	logic [15:0] parallel_output_bus;
	// pull-ups hold the bus high while the buffers float
	assign parallel_output_bus = data_oe_n ? 16'hFFFF : data_out;
	modport dev (
		input hold_n, cs_n, rd_n, result_status_select, cal_burst,
		input interleave_trim_n, adc_reset, master_clock_in,
		output acquired_n, data_out, data_oe_n, eoc_n, serial_clk, serial_result_out
	);
	modport host (
		output hold_n, cs_n, rd_n, result_status_select, cal_burst,
		output interleave_trim_n, adc_reset, master_clock_in,
		input acquired_n, parallel_output_bus, eoc_n, serial_clk, serial_result_out
	);
endinterface

/* File: adcc_dev.sv */
// adcc_dev: converter-side control, calibration and readout logic
//
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/100ps
module adcc_dev #(
	parameter int CAL_TICKS = adcc_pkg::CAL_TICKS,
	parameter int TRIM_CONVS = adcc_pkg::TRIM_CONVS
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// pins
	adcc_if.dev pins,
	// user side
	input wire logic [15:0] sample_i,
	input wire logic free_run_i,
	output logic cal_busy_o,
	output logic [15:0] result_o
);
	localparam logic [20:0] CAL_LAST = 21'(CAL_TICKS - 1);
	localparam logic [16:0] TRIM_LAST = 17'(TRIM_CONVS - 1);
	localparam logic [20:0] CONV_LAST = 21'(adcc_pkg::CONV_TICKS - 1);
	localparam logic [20:0] SLICE_LAST = 21'(adcc_pkg::SLICE_TICKS - 1);
	localparam logic [20:0] ACQ_LAST = 21'(adcc_pkg::ACQ_TICKS - 1);
	localparam logic [4:0] EXT_TO = 5'(adcc_pkg::EXT_TIMEOUT);
	localparam logic [2:0] INT_LAST = 3'(adcc_pkg::INT_DIV - 1);
	localparam logic [1:0] SER_LAST = 2'(adcc_pkg::SER_HALF - 1);

	////////////////////////////////////////////////////////////////
	// pin synchronisers
	localparam int NS = 8;
	logic [NS-1:0] pin_raw;
	logic [NS-1:0] s1_q;
	logic [NS-1:0] s2_q;
	assign pin_raw = {pins.hold_n, pins.cs_n, pins.rd_n, pins.result_status_select,
		pins.cal_burst, pins.interleave_trim_n, pins.adc_reset, pins.master_clock_in};
	genvar gi;
	generate
		for (gi = 0; gi < NS; gi++) begin : g_sync
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					s1_q[gi] <= 1'b1;
					s2_q[gi] <= 1'b1;
				end else begin
					s1_q[gi] <= pin_raw[gi];
					s2_q[gi] <= s1_q[gi];
				end
			end
		end
	endgenerate
	wire hold_s = s2_q[7];
	wire cs_s = s2_q[6];
	wire rd_s = s2_q[5];
	wire rss_s = s2_q[4];
	wire burst_s = s2_q[3];
	wire trim_n_s = s2_q[2];
	wire areset_s = s2_q[1];
	wire mclk_s = s2_q[0];

	////////////////////////////////////////////////////////////////
	// master clock tick: external edges, else internal oscillator
	logic mclk_prev_q;
	logic [4:0] ext_idle_q;
	logic ext_mode_q;
	logic [2:0] int_div_q;
	wire ext_rise = mclk_s & ~mclk_prev_q;
	wire int_tick = (int_div_q == INT_LAST);
	// a grounded input never rises, so the watchdog falls back to internal
	wire tick = ext_mode_q ? ext_rise : int_tick;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mclk_prev_q <= 1'b1;
			ext_idle_q <= 5'h00;
			ext_mode_q <= 1'b0;
			int_div_q <= 3'h0;
		end else begin
			mclk_prev_q <= mclk_s;
			int_div_q <= int_tick ? 3'h0 : int_div_q + 3'h1;
			if (ext_rise) begin
				ext_idle_q <= 5'h00;
				ext_mode_q <= 1'b1;
			end else if (ext_idle_q == EXT_TO) begin
				ext_mode_q <= 1'b0;
			end else begin
				ext_idle_q <= ext_idle_q + 5'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// conversion and calibration sequencer
	adcc_pkg::adcc_state_e st_q;
	logic [20:0] cnt_q;
	logic [16:0] trim_q;
	logic trim_done_q;
	logic acq_n_q;
	logic hold_prev_q;
	logic [15:0] held_q;
	logic [15:0] result_q;
	logic new_res;
	// in free-run the converter's own acquired_n drives its hold
	wire hold_src = free_run_i ? acq_n_q : hold_s;
	wire hold_fall = hold_prev_q & ~hold_src;
	wire cnt_end = tick && (cnt_q == 21'h000000);
	wire trim_on = ~trim_n_s;
	wire stat_rd = ~cs_s & ~rd_s & ~rss_s;
	assign new_res = (st_q == adcc_pkg::S_CONV) && cnt_end;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= adcc_pkg::S_CAL;
			cnt_q <= CAL_LAST;
			acq_n_q <= 1'b1;
			hold_prev_q <= 1'b1;
			trim_q <= 17'h00000;
			held_q <= 16'h0000;
			result_q <= 16'h0000;
		end else begin
			hold_prev_q <= hold_src;
			if (tick && cnt_q != 21'h000000) begin
				cnt_q <= cnt_q - 21'h000001;
			end
			if (areset_s) begin
				st_q <= adcc_pkg::S_CAL;
				cnt_q <= CAL_LAST;
				acq_n_q <= 1'b1;
			end else begin
				unique case (st_q)
					adcc_pkg::S_CAL: begin
						if (cnt_end) begin
							// burst keeps looping whole calibration cycles
							if (burst_s) begin
								cnt_q <= CAL_LAST;
							end else begin
								st_q <= adcc_pkg::S_ACQ;
								cnt_q <= ACQ_LAST;
							end
						end
					end
					adcc_pkg::S_IDLE: begin
						if (burst_s) begin
							st_q <= adcc_pkg::S_CAL;
							cnt_q <= CAL_LAST;
							acq_n_q <= 1'b1;
						end else if (hold_fall) begin
							st_q <= adcc_pkg::S_CONV;
							cnt_q <= CONV_LAST;
							held_q <= sample_i;
							acq_n_q <= 1'b1;
						end
					end
					adcc_pkg::S_CONV: begin
						if (cnt_end) begin
							result_q <= held_q;
							st_q <= trim_on ? adcc_pkg::S_SLICE : adcc_pkg::S_ACQ;
							cnt_q <= trim_on ? SLICE_LAST : ACQ_LAST;
						end
					end
					adcc_pkg::S_SLICE: begin
						if (cnt_end) begin
							trim_q <= (trim_q == TRIM_LAST) ? 17'h00000 : trim_q + 17'h00001;
							st_q <= adcc_pkg::S_ACQ;
							cnt_q <= ACQ_LAST;
						end
					end
					adcc_pkg::S_ACQ: begin
						if (cnt_end) begin
							st_q <= adcc_pkg::S_IDLE;
							acq_n_q <= 1'b0;
						end
					end
					default: begin
						st_q <= adcc_pkg::S_CAL;
						cnt_q <= CAL_LAST;
					end
				endcase
			end
		end
	end

	// full interleaved calibration done; cleared as a status read ends, so it is seen
	logic stat_rd_prev_q;
	wire stat_rd_end = stat_rd_prev_q & ~stat_rd;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trim_done_q <= 1'b0;
			stat_rd_prev_q <= 1'b0;
		end else begin
			stat_rd_prev_q <= stat_rd;
			if (st_q == adcc_pkg::S_SLICE && cnt_end && trim_q == TRIM_LAST) begin
				trim_done_q <= 1'b1;
			end else if (stat_rd_end) begin
				trim_done_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// parallel port
	logic [15:0] data_q;
	logic oe_n_q;
	logic eoc_n_q;
	logic cal_busy_q;
	logic [7:0] status;
	wire rd_act = ~cs_s & ~rd_s;
	always_comb begin
		status = 8'h00;
		status[adcc_pkg::ST_CAL] = (st_q == adcc_pkg::S_CAL);
		status[adcc_pkg::ST_CONV] = (st_q == adcc_pkg::S_CONV) || (st_q == adcc_pkg::S_SLICE);
		status[adcc_pkg::ST_EOC] = ~eoc_n_q;
		status[adcc_pkg::ST_TRIM] = trim_done_q;
		status[adcc_pkg::ST_EXT] = ext_mode_q;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_q <= 16'h0000;
			oe_n_q <= 1'b1;
			eoc_n_q <= 1'b1;
			cal_busy_q <= 1'b1;
		end else begin
			// tied-low strobes keep the word on the bus at all times
			data_q <= rss_s ? result_q : {8'h00, status};
			oe_n_q <= ~rd_act;
			cal_busy_q <= status[adcc_pkg::ST_CAL];
			if (new_res) begin
				eoc_n_q <= 1'b0;
			end else if (rd_act && rss_s) begin
				eoc_n_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// serial result, shifted on falling edge so it is steady at rising
	logic [15:0] ser_q;
	logic [4:0] ser_bits_q;
	logic [1:0] ser_ph_q;
	logic sclk_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ser_q <= 16'h0000;
			ser_bits_q <= 5'h00;
			ser_ph_q <= 2'h0;
			sclk_q <= 1'b0;
		end else if (new_res) begin
			ser_q <= held_q;
			ser_bits_q <= 5'h10;
			ser_ph_q <= 2'h0;
			sclk_q <= 1'b0;
		end else if (ser_bits_q != 5'h00) begin
			ser_ph_q <= (ser_ph_q == SER_LAST) ? 2'h0 : ser_ph_q + 2'h1;
			if (ser_ph_q == SER_LAST) begin
				sclk_q <= ~sclk_q;
				if (sclk_q) begin
					ser_q <= {ser_q[14:0], 1'b0};
					ser_bits_q <= ser_bits_q - 5'h01;
				end
			end
		end
	end

	assign pins.acquired_n = acq_n_q;
	assign pins.data_out = data_q;
	assign pins.data_oe_n = oe_n_q;
	assign pins.eoc_n = eoc_n_q;
	assign pins.serial_clk = sclk_q;
	assign pins.serial_result_out = ser_q[15];
	assign result_o = result_q;
	assign cal_busy_o = cal_busy_q;
endmodule

/* File: adcc_host.sv */
// adcc_host: wishbone controller driving the converter pins
`timescale 1ns/100ps
module adcc_host (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic irq_o,
	// pins
	adcc_if.host pins
);
	localparam logic [2:0] HOLD_LAST = 3'(adcc_pkg::HOLD_LOW_CYC);
	localparam logic [2:0] RST_LAST = 3'(adcc_pkg::RST_PULSE_CYC);
	localparam logic [2:0] RD_LAST = 3'(adcc_pkg::RD_HOLD_CYC);
	localparam logic [1:0] MCLK_LAST = 2'(adcc_pkg::MCLK_HALF - 1);

	////////////////////////////////////////////////////////////////
	// pin synchronisers: acquired_n, eoc_n, bus
	logic [17:0] s1_q;
	logic [17:0] s2_q;
	always_ff @(posedge clk_i) begin
		s1_q <= {pins.acquired_n, pins.eoc_n, pins.parallel_output_bus};
		s2_q <= s1_q;
	end
	wire acq_s = s2_q[17];
	wire eoc_s = s2_q[16];
	wire [15:0] bus_s = s2_q[15:0];

	////////////////////////////////////////////////////////////////
	// wishbone registers
	logic [31:0] ctrl_q;
	logic [15:0] result_q;
	logic [7:0] adcst_q;
	logic [2:0] irq_st_q;
	logic [2:0] irq_msk_q;
	logic hold_q;
	logic ack_q;
	logic [31:0] dat_q;
	logic acq_prev_q;
	logic res_ev;
	logic st_ev;
	wire req = cyc_i & stb_i & ~ack_q;
	wire wr = req & we_i & sel_i[0];
	wire wr_cmd = wr && adr_i == adcc_pkg::A_CMD;
	wire acq_ev = acq_prev_q & ~acq_s;
	wire [2:0] ev = {acq_ev, st_ev, res_ev};
	logic [31:0] rdata;
	always_comb begin
		unique case (adr_i)
			adcc_pkg::A_CTRL: rdata = ctrl_q;
			adcc_pkg::A_STAT: rdata = {29'h0, hold_q, ~eoc_s, ~acq_s};
			adcc_pkg::A_RESULT: rdata = {16'h0000, result_q};
			adcc_pkg::A_ADCST: rdata = {24'h000000, adcst_q};
			adcc_pkg::A_IRQST: rdata = {29'h0, irq_st_q};
			adcc_pkg::A_IRQMSK: rdata = {29'h0, irq_msk_q};
			default: rdata = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= adcc_pkg::CTRL_RST;
			irq_st_q <= 3'h0;
			irq_msk_q <= 3'h0;
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
			acq_prev_q <= 1'b1;
		end else begin
			ack_q <= req;
			acq_prev_q <= acq_s;
			if (req) begin
				dat_q <= rdata;
			end
			if (wr && adr_i == adcc_pkg::A_CTRL) begin
				ctrl_q <= {28'h0, dat_i[3:0]};
			end
			if (wr && adr_i == adcc_pkg::A_IRQMSK) begin
				irq_msk_q <= dat_i[2:0];
			end
			// set wins over a write-one clear in the same cycle
			if (wr && adr_i == adcc_pkg::A_IRQST) begin
				irq_st_q <= (irq_st_q & ~dat_i[2:0]) | ev;
			end else begin
				irq_st_q <= irq_st_q | ev;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// hold pulse, converter reset, master clock
	logic [2:0] hold_cnt_q;
	logic [2:0] rst_cnt_q;
	logic areset_q;
	logic [1:0] mdiv_q;
	logic mclk_q;
	// a start before acquisition completes is dropped
	wire start_ok = wr_cmd && dat_i[adcc_pkg::K_START] && ~acq_s && ~hold_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hold_q <= 1'b0;
			hold_cnt_q <= 3'h0;
			rst_cnt_q <= RST_LAST;
			areset_q <= 1'b1;
			mdiv_q <= 2'h0;
			mclk_q <= 1'b0;
		end else begin
			if (start_ok) begin
				hold_q <= 1'b1;
				hold_cnt_q <= HOLD_LAST;
			end else if (hold_cnt_q != 3'h0) begin
				hold_cnt_q <= hold_cnt_q - 3'h1;
			end else begin
				hold_q <= 1'b0;
			end
			if (wr_cmd && dat_i[adcc_pkg::K_RESET]) begin
				rst_cnt_q <= RST_LAST;
			end else if (rst_cnt_q != 3'h0) begin
				rst_cnt_q <= rst_cnt_q - 3'h1;
			end
			// next value of (count != 0), so the pin comes straight from a flop
			areset_q <= (wr_cmd && dat_i[adcc_pkg::K_RESET]) || (rst_cnt_q > 3'h1);
			mdiv_q <= (mdiv_q == MCLK_LAST) ? 2'h0 : mdiv_q + 2'h1;
			// a grounded clock pin hands the converter its own oscillator
			if (~ctrl_q[adcc_pkg::C_EXTCLK]) begin
				mclk_q <= 1'b0;
			end else if (mdiv_q == MCLK_LAST) begin
				mclk_q <= ~mclk_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// parallel read sequencer
	adcc_pkg::adcc_hstate_e hs_q;
	logic [2:0] rd_cnt_q;
	logic rd_n_q;
	logic rss_q;
	logic st_pend_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hs_q <= adcc_pkg::H_IDLE;
			rd_cnt_q <= 3'h0;
			rd_n_q <= 1'b1;
			rss_q <= 1'b1;
			st_pend_q <= 1'b0;
			result_q <= 16'h0000;
			adcst_q <= 8'h00;
			res_ev <= 1'b0;
			st_ev <= 1'b0;
		end else begin
			res_ev <= 1'b0;
			st_ev <= 1'b0;
			if (wr_cmd && dat_i[adcc_pkg::K_STATRD]) begin
				st_pend_q <= 1'b1;
			end
			unique case (hs_q)
				adcc_pkg::H_IDLE: begin
					if (~eoc_s && ctrl_q[adcc_pkg::C_AUTORD]) begin
						hs_q <= adcc_pkg::H_READ;
						rd_n_q <= 1'b0;
						rss_q <= 1'b1;
						rd_cnt_q <= RD_LAST;
					end else if (st_pend_q) begin
						hs_q <= adcc_pkg::H_READ;
						rd_n_q <= 1'b0;
						rss_q <= 1'b0;
						rd_cnt_q <= RD_LAST;
						st_pend_q <= 1'b0;
					end
				end
				adcc_pkg::H_READ: begin
					if (rd_cnt_q != 3'h0) begin
						rd_cnt_q <= rd_cnt_q - 3'h1;
					end else begin
						rd_n_q <= 1'b1;
						hs_q <= adcc_pkg::H_GAP;
						rd_cnt_q <= RD_LAST;
						if (rss_q) begin
							result_q <= bus_s;
							res_ev <= 1'b1;
						end else begin
							adcst_q <= bus_s[7:0];
							st_ev <= 1'b1;
						end
					end
				end
				adcc_pkg::H_GAP: begin
					// lets eoc_n settle high before the next look
					if (rd_cnt_q != 3'h0) begin
						rd_cnt_q <= rd_cnt_q - 3'h1;
					end else begin
						hs_q <= adcc_pkg::H_IDLE;
						rss_q <= 1'b1;
					end
				end
				default: hs_q <= adcc_pkg::H_IDLE;
			endcase
		end
	end

	logic irq_q;
	always_ff @(posedge clk_i) begin
		irq_q <= rst_i ? 1'b0 : |(irq_st_q & irq_msk_q);
	end

	assign pins.hold_n = ~hold_q;
	assign pins.cs_n = rd_n_q;
	assign pins.rd_n = rd_n_q;
	assign pins.result_status_select = rss_q;
	assign pins.cal_burst = ctrl_q[adcc_pkg::C_BURST];
	assign pins.interleave_trim_n = ~ctrl_q[adcc_pkg::C_TRIM];
	assign pins.adc_reset = areset_q;
	assign pins.master_clock_in = mclk_q;
	assign dat_o = dat_q;
	assign ack_o = ack_q;
	assign irq_o = irq_q;
endmodule

/* File: adcc_monitor.sv */
// adcc_monitor: timing checks on the pins between converter and controller
`timescale 1ns/100ps
module adcc_monitor (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// pins
	input wire logic hold_n,
	input wire logic acquired_n,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic result_status_select,
	input wire logic cal_burst,
	input wire logic interleave_trim_n,
	input wire logic data_oe_n,
	input wire logic eoc_n,
	input wire logic serial_clk,
	input wire logic serial_result_out
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////
	// burst length counter; saturates well past the longest conversion plus slice
	logic [8:0] burst_q;
	logic [8:0] burst_d;
	assign burst_d = !cal_burst ? 9'h000 : ((burst_q == 9'h1FF) ? burst_q : burst_q + 9'h001);
	always_ff @(posedge clk_i) begin
		burst_q <= rst_i ? 9'h000 : burst_d;
	end
	////////////////////////////////////////////////////////////////
	property p_start_accept;
		$fell(hold_n) && !acquired_n |-> ##[1:8] acquired_n;
	endproperty
	property p_conv_plain;
		$fell(hold_n) && !acquired_n && !cal_burst && interleave_trim_n
			|-> ##[70:110] $fell(acquired_n);
	endproperty
	property p_conv_trim;
		$fell(hold_n) && !acquired_n && !cal_burst && !interleave_trim_n
			|-> ##[150:200] $fell(acquired_n);
	endproperty
	property p_oe_read;
		$fell(data_oe_n) |-> !$past(cs_n, 2) && !$past(rd_n, 2);
	endproperty
	property p_oe_idle;
		(cs_n && rd_n)[*4] |-> data_oe_n;
	endproperty
	property p_oe_cont;
		(!cs_n && !rd_n)[*4] |-> !data_oe_n;
	endproperty
	property p_eoc_in_acq;
		$fell(eoc_n) |-> acquired_n;
	endproperty
	property p_eoc_clear;
		$fell(cs_n) ##1 (result_status_select && !cs_n) |-> ##[1:4] eoc_n;
	endproperty
	property p_ser_stable;
		serial_clk |-> $stable(serial_result_out);
	endproperty
	property p_ser_half;
		$rose(serial_clk) |=> serial_clk ##1 !serial_clk;
	endproperty
	property p_burst_hold;
		burst_q == 9'h1FF |-> acquired_n;
	endproperty
	a_start_accept: assert property (p_start_accept) else $error("hold edge not taken");
	a_conv_plain: assert property (p_conv_plain) else $error("conversion length off");
	a_conv_trim: assert property (p_conv_trim) else $error("slice length off");
	a_oe_read: assert property (p_oe_read) else $error("bus driven without read");
	a_oe_idle: assert property (p_oe_idle) else $error("bus not released");
	a_oe_cont: assert property (p_oe_cont) else $error("word not presented");
	a_eoc_in_acq: assert property (p_eoc_in_acq) else $error("done outside acquisition");
	a_eoc_clear: assert property (p_eoc_clear) else $error("done not cleared by read");
	a_ser_stable: assert property (p_ser_stable) else $error("serial data moved");
	a_ser_half: assert property (p_ser_half) else $error("serial clock width off");
	a_burst_hold: assert property (p_burst_hold) else $error("burst left calibration");
	c_conv: cover property ($fell(hold_n) && !acquired_n && interleave_trim_n);
	c_trim: cover property ($fell(hold_n) && !acquired_n && !interleave_trim_n);
	c_burst: cover property (burst_q == 9'h1FF);
endmodule

/* File: testbench.sv */
// testbench: converter and controller joined at their pins, driven over wishbone
`timescale 1ns/100ps
`define CHK(act, exp) begin check_count++; if ((act) !== (exp)) begin miscompares++; \
	$display("[ERR] %0t got %h expected %h", $time, (act), (exp)); end end
module testbench;
	localparam int WATCHDOG_CYC = 30000;
	logic clk, rst, cyc, stb, we, ack, irq, free_run, cal_busy;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] dat_w, dat_r, rd;
	logic [15:0] sample, res, ser_shift;
	int miscompares, check_count, fall_cnt, i;
	adcc_if pins();
	adcc_dev #(.CAL_TICKS(40), .TRIM_CONVS(4)) i_adcc_dev (.clk_i(clk), .rst_i(rst),
		.pins(pins), .sample_i(sample), .free_run_i(free_run), .cal_busy_o(cal_busy),
		.result_o(res));
	adcc_host i_adcc_host (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .irq_o(irq),
		.pins(pins));
	adcc_monitor i_adcc_monitor (.clk_i(clk), .rst_i(rst), .hold_n(pins.hold_n),
		.acquired_n(pins.acquired_n), .cs_n(pins.cs_n), .rd_n(pins.rd_n),
		.result_status_select(pins.result_status_select), .cal_burst(pins.cal_burst),
		.interleave_trim_n(pins.interleave_trim_n), .data_oe_n(pins.data_oe_n),
		.eoc_n(pins.eoc_n), .serial_clk(pins.serial_clk),
		.serial_result_out(pins.serial_result_out));
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge pins.serial_clk) ser_shift <= {ser_shift[14:0], pins.serial_result_out};
	always @(negedge pins.acquired_n) fall_cnt++;
	////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// one classic cycle; entered just after a rising edge, leaves one idle cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= d;
		sel <= 4'hF;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			miscompares++;
			$display("[ERR] %0t bus request not answered", $time);
		end
		rd = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic poll(input logic [7:0] a, input int b);
		int n;
		n = 0;
		do begin
			wb(1'b0, a, 32'h0);
			n++;
		end while (rd[b] !== 1'b1 && n < 200);
		`CHK(rd[b], 1'b1)
	endtask
	task automatic conv(input logic [15:0] v);
		poll(adcc_pkg::A_STAT, 0);
		sample <= v;
		wb(1'b1, adcc_pkg::A_IRQST, 32'h0000_0007);
		wb(1'b1, adcc_pkg::A_CMD, 32'h0000_0001);
		poll(adcc_pkg::A_IRQST, 0);
		wb(1'b0, adcc_pkg::A_RESULT, 32'h0);
		`CHK(rd[15:0], v)
		`CHK(res, v)
		`CHK(pins.eoc_n, 1'b1)
		repeat (80) @(posedge clk);
		`CHK(ser_shift, v)
	endtask
	task automatic stat();
		wb(1'b1, adcc_pkg::A_IRQST, 32'h0000_0002);
		wb(1'b1, adcc_pkg::A_CMD, 32'h0000_0004);
		poll(adcc_pkg::A_IRQST, 1);
		wb(1'b0, adcc_pkg::A_ADCST, 32'h0);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		#(WATCHDOG_CYC * 100);
		miscompares++;
		$display("[ERR] %0t watchdog expired", $time);
		final_report();
	end
	initial begin
		rst = 1'b1;
		{cyc, stb, we, free_run} = 4'h0;
		adr = 8'h00;
		sel = 4'h0;
		dat_w = 32'h0;
		sample = 16'h0000;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		`CHK(cal_busy, 1'b1)
		wb(1'b0, adcc_pkg::A_CTRL, 32'h0);
		`CHK(rd, adcc_pkg::CTRL_RST)
		wb(1'b1, 8'h1C, 32'hFFFF_FFFF);
		wb(1'b0, 8'h1C, 32'h0);
		`CHK(rd, 32'h0)
		poll(adcc_pkg::A_STAT, 0);
		`CHK(cal_busy, 1'b0)
		conv(16'hA5C3);
		conv(16'h0001);
		conv(16'h8000);
		wb(1'b1, adcc_pkg::A_IRQMSK, 32'h0000_0001);
		@(posedge clk);
		`CHK(irq, 1'b1)
		wb(1'b1, adcc_pkg::A_IRQMSK, 32'h0);
		`CHK(irq, 1'b0)
		wb(1'b1, adcc_pkg::A_IRQMSK, 32'h0000_0001);
		wb(1'b1, adcc_pkg::A_IRQST, 32'h0000_0001);
		`CHK(irq, 1'b0)
		stat();
		`CHK(rd[4:0], 5'h00)
		wb(1'b1, adcc_pkg::A_CTRL, 32'h0000_000C);
		conv(16'h3C5A);
		stat();
		`CHK(rd[4], 1'b1)
		wb(1'b1, adcc_pkg::A_CTRL, 32'h0000_000A);
		for (i = 0; i < 3; i++) begin
			conv(16'(16'h1111 * (i + 1)));
		end
		stat();
		`CHK(rd[3], 1'b0)
		conv(16'hFFFE);
		stat();
		`CHK(rd[3], 1'b1)
		wb(1'b1, adcc_pkg::A_CTRL, 32'h0000_0009);
		repeat (600) @(posedge clk);
		`CHK(cal_busy, 1'b1)
		`CHK(pins.acquired_n, 1'b1)
		wb(1'b1, adcc_pkg::A_CTRL, 32'h0000_0008);
		poll(adcc_pkg::A_STAT, 0);
		wb(1'b1, adcc_pkg::A_CMD, 32'h0000_0002);
		repeat (8) @(posedge clk);
		`CHK(cal_busy, 1'b1)
		poll(adcc_pkg::A_STAT, 0);
		free_run <= 1'b1;
		fall_cnt = 0;
		repeat (400) @(posedge clk);
		`CHK(fall_cnt >= 3, 1'b1)
		free_run <= 1'b0;
		repeat (200) @(posedge clk);
		final_report();
	end
endmodule
